// ---- gws_pkg.sv ----
// Functional notes
// [RL1] A pin's wake event sets its status bit, ignoring all enables.
// [RL2] Standby power-on reset clears all three status registers to 0x00.
// [RL3] Main-power reset, soft reset and PCI reset leave status bits unchanged.
// [RL4] Writing 1 to any of bits 7..0 clears that status bit.
// [RL5] Writing 0 to a status bit leaves it unchanged.
// [RL6] Offset 05 holds pins 1_0..1_7 in bits 0..7.
// [RL7] Offset 06 holds pins 2_0..2_7 in bits 0..7.
// [RL8] Offset 07 holds pins 3_0..3_3, 4_1, 4_3, 6_0, 6_1 in bits 0..7.
// [RL9] Wake request needs status, source enable and global enable all set.
// [RL10] Status stays set until cleared; a coincident event beats the clearing write.
package gws_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 3;

  localparam logic [ADDR_W-1:0] OFFSET_WAKE_STATUS_A = 8'h05;
  localparam logic [ADDR_W-1:0] OFFSET_WAKE_STATUS_B = 8'h06;
  localparam logic [ADDR_W-1:0] OFFSET_WAKE_STATUS_C = 8'h07;

  localparam logic [DATA_W-1:0] RESET_WAKE_STATUS = 8'h00;
  localparam logic [DATA_W-1:0] UNMAPPED_READ_VALUE = 8'h00;

  localparam logic [DATA_W*NUM_REGS-1:0] RESET_WAKE_REQUEST   = 24'h000000;
  localparam logic                       RESET_WAKE_REQUEST_N = 1'h1;

  // Register file reached over the plain port.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr;
    logic              rd;
  } gws_bus_req_t;

  // Pins of the first group, bit 7 down to bit 0.
  typedef struct packed {
    logic gpio_pin_1_7;
    logic gpio_pin_1_6;
    logic gpio_pin_1_5;
    logic gpio_pin_1_4;
    logic gpio_pin_1_3;
    logic gpio_pin_1_2;
    logic gpio_pin_1_1;
    logic gpio_pin_1_0;
  } gws_grp_a_t;

  // Pins of the second group, bit 7 down to bit 0.
  typedef struct packed {
    logic gpio_pin_2_7;
    logic gpio_pin_2_6;
    logic gpio_pin_2_5;
    logic gpio_pin_2_4;
    logic gpio_pin_2_3;
    logic gpio_pin_2_2;
    logic gpio_pin_2_1;
    logic gpio_pin_2_0;
  } gws_grp_b_t;

  // Mixed third group, bit 7 down to bit 0.
  typedef struct packed {
    logic gpio_pin_6_1;
    logic gpio_pin_6_0;
    logic gpio_pin_4_3;
    logic gpio_pin_4_1;
    logic gpio_pin_3_3;
    logic gpio_pin_3_2;
    logic gpio_pin_3_1;
    logic gpio_pin_3_0;
  } gws_grp_c_t;

  // All 24 wake sources; the same layout carries events, enables and requests.
  typedef struct packed {
    gws_grp_c_t grp_c;
    gws_grp_b_t grp_b;
    gws_grp_a_t grp_a;
  } gws_pins_t;

endpackage : gws_pkg

// ---- gws_latch.sv ----
`timescale 1ns/1ps
module gws_latch (
  // Clock and standby reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Wake events of the eight sources
  input  wire logic [gws_pkg::DATA_W-1:0]   i_event,
  // Clearing write
  input  wire logic                         i_clr_wr,
  input  wire logic [gws_pkg::DATA_W-1:0]   i_clr_mask,
  // Sticky status
  output logic      [gws_pkg::DATA_W-1:0]   o_status
);

  logic [gws_pkg::DATA_W-1:0] status_q;
  logic [gws_pkg::DATA_W-1:0] status_d;
  logic [gws_pkg::DATA_W-1:0] clear_bits;

  always_comb begin
    clear_bits = i_clr_wr ? i_clr_mask : gws_pkg::RESET_WAKE_STATUS; // RL4 RL5
    // The event term is applied last so it wins over a coincident clear.
    status_d = (status_q & ~clear_bits) | i_event; // RL1 RL10
  end

  // Only the standby reset reaches these flops.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      status_q <= gws_pkg::RESET_WAKE_STATUS; // RL2
    end else begin
      status_q <= status_d;
    end
  end

  assign o_status = status_q;

endmodule : gws_latch

// ---- gws_top.sv ----
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module gws_top (
  // Clock and standby power-on reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // Other resets of the device
  input  wire logic                         i_main_power_on_reset,
  input  wire logic                         i_soft_reset,
  input  wire logic                         i_pci_reset,
  // Register port
  input  wire logic [gws_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [gws_pkg::DATA_W-1:0]   i_wr_data,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [gws_pkg::DATA_W-1:0]   o_rd_data,
  // Wake sources and enables
  input  wire gws_pkg::gws_pins_t           i_wake_event,
  input  wire gws_pkg::gws_pins_t           i_wake_source_enable,
  input  wire logic                         i_wake_global_enable,
  // Status and wake request
  output gws_pkg::gws_pins_t                o_wake_status,
  output gws_pkg::gws_pins_t                o_wake_request,
  output logic                              o_wake_request_out_n
);

  // Returns the index of the status register at an address, or NUM_REGS.
  function automatic logic [1:0] reg_index(input logic [gws_pkg::ADDR_W-1:0] addr);
    logic [1:0] idx;
    idx = 2'h3;
    case (addr)
      gws_pkg::OFFSET_WAKE_STATUS_A: idx = 2'h0; // RL6
      gws_pkg::OFFSET_WAKE_STATUS_B: idx = 2'h1; // RL7
      gws_pkg::OFFSET_WAKE_STATUS_C: idx = 2'h2; // RL8
      default:                       idx = 2'h3;
    endcase
    return idx;
  endfunction : reg_index

  gws_pkg::gws_bus_req_t bus;
  logic [1:0]            wr_idx;
  logic [1:0]            rd_idx;
  logic                  other_reset;

  logic [gws_pkg::NUM_REGS-1:0][gws_pkg::DATA_W-1:0] event_grp;
  logic [gws_pkg::NUM_REGS-1:0][gws_pkg::DATA_W-1:0] status_grp;

  assign bus.addr    = i_addr;
  assign bus.wr_data = i_wr_data;
  assign bus.wr      = i_wr;
  assign bus.rd      = i_rd;

  assign wr_idx = reg_index(bus.addr);
  assign rd_idx = reg_index(bus.addr);

  // These resets clear only the read pipeline; the latches never see them.
  assign other_reset = i_main_power_on_reset | i_soft_reset | i_pci_reset; // RL3

  // Events map bit for bit onto the three registers through the pin structs.
  assign event_grp[0] = i_wake_event.grp_a; // RL6
  assign event_grp[1] = i_wake_event.grp_b; // RL7
  assign event_grp[2] = i_wake_event.grp_c; // RL8

  // Events are fed in with no enable gating at all.
  genvar g;
  generate
    for (g = 0; g < gws_pkg::NUM_REGS; g++) begin : g_latch
      gws_latch u_latch (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_event    (event_grp[g]),                               // RL1
        .i_clr_wr   (bus.wr && (wr_idx == 2'(g))),                // RL4
        .i_clr_mask (bus.wr_data),                                // RL5
        .o_status   (status_grp[g])
      );
    end
  endgenerate

  assign o_wake_status.grp_a = status_grp[0];
  assign o_wake_status.grp_b = status_grp[1];
  assign o_wake_status.grp_c = status_grp[2];

  // Read data: one cycle after the strobe, zero in every other cycle.
  logic [gws_pkg::DATA_W-1:0] rd_data_q;
  logic [gws_pkg::DATA_W-1:0] rd_data_d;

  always_comb begin
    rd_data_d = gws_pkg::UNMAPPED_READ_VALUE;
    if (bus.rd && (rd_idx != 2'h3)) begin
      rd_data_d = status_grp[rd_idx];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || other_reset) begin
      rd_data_q <= gws_pkg::UNMAPPED_READ_VALUE;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign o_rd_data = rd_data_q;

  // Wake request, registered so the pin never glitches on decode.
  gws_pkg::gws_pins_t req_q;
  gws_pkg::gws_pins_t req_d;
  logic               req_n_q;
  logic               req_n_d;

  always_comb begin
    req_d   = i_wake_global_enable ?
              (o_wake_status & i_wake_source_enable) : gws_pkg::RESET_WAKE_REQUEST; // RL9
    req_n_d = ~(|req_d); // RL9
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_q   <= gws_pkg::RESET_WAKE_REQUEST;
      req_n_q <= gws_pkg::RESET_WAKE_REQUEST_N;
    end else begin
      req_q   <= req_d;
      req_n_q <= req_n_d;
    end
  end

  assign o_wake_request       = req_q;
  assign o_wake_request_out_n = req_n_q;

endmodule : gws_top

// ---- gws_properties.sv ----
`timescale 1ns/1ps
module gws_properties (
  // Clock, reset and register port
  input wire logic               i_clk,
  input wire logic               i_rst,
  input wire logic [7:0]         i_addr,
  input wire logic [7:0]         i_wr_data,
  input wire logic               i_wr,
  input wire logic               i_rd,
  input wire logic [7:0]         o_rd_data,
  // Wake side
  input wire gws_pkg::gws_pins_t i_wake_event,
  input wire gws_pkg::gws_pins_t i_wake_source_enable,
  input wire logic               i_wake_global_enable,
  input wire gws_pkg::gws_pins_t o_wake_status,
  input wire gws_pkg::gws_pins_t o_wake_request,
  input wire logic               o_wake_request_out_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Bits cleared by a write; offsets outside the bank clear nothing.
  function automatic logic [23:0] wm(logic w, logic [7:0] a, logic [7:0] d);
    return !w ? 24'h000000 : a == 8'h05 ? {16'h0000, d} : a == 8'h06 ? {8'h00, d, 8'h00}
         : a == 8'h07 ? {d, 16'h0000} : 24'h000000;
  endfunction : wm
  function automatic logic [7:0] rs(logic [7:0] a, logic [23:0] s);
    return a == 8'h05 ? s[7:0] : a == 8'h06 ? s[15:8] : a == 8'h07 ? s[23:16] : 8'h00;
  endfunction : rs
  property p_set;
    i_wake_event != 0 |=> (o_wake_status & $past(i_wake_event)) == $past(i_wake_event);
  endproperty
  a_set: assert property (p_set) else $error("event did not set status");
  property p_next;
    1 |=> o_wake_status == $past((o_wake_status & ~wm(i_wr, i_addr, i_wr_data)) | i_wake_event);
  endproperty
  a_next: assert property (p_next) else $error("status update wrong");
  property p_noclr;
    !i_wr |=> ($past(o_wake_status) & ~o_wake_status) == 0;
  endproperty
  a_noclr: assert property (p_noclr) else $error("status fell without write");
  property p_rst;
    $past(i_rst) |-> o_wake_status == 0 && o_wake_request == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("status not cleared by reset");
  property p_rd;
    i_rd |=> o_rd_data == rs($past(i_addr), $past(o_wake_status));
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_idle;
    !i_rd |=> o_rd_data == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_req;
    1 |=> o_wake_request == $past(o_wake_status & i_wake_source_enable
                                  & {24{i_wake_global_enable}});
  endproperty
  a_req: assert property (p_req) else $error("wake request wrong");
  property p_outn;
    o_wake_request_out_n == (o_wake_request == 0);
  endproperty
  a_outn: assert property (p_outn) else $error("wake output level wrong");
  c_race: cover property (i_wr && i_wake_event != 0);
  c_wake: cover property (!o_wake_request_out_n);
  c_rdc: cover property (i_rd && i_addr == 8'h07);
endmodule : gws_properties
bind gws_top gws_properties u_props (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic               i_clk, i_rst, i_wr, i_rd, i_wake_global_enable, o_wake_request_out_n;
  logic               i_main_power_on_reset, i_soft_reset, i_pci_reset;
  logic [7:0]         i_addr, i_wr_data, o_rd_data, rd;
  gws_pkg::gws_pins_t i_wake_event, i_wake_source_enable, o_wake_status, o_wake_request;
  logic [23:0]        m, req, wmask;
  int                 err_count = 0, n_checks = 0, op;
  gws_top dut (.*);
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    i_clk = 1'h0;
    forever #10 i_clk = ~i_clk;
  end
  initial begin
    #50000;
    err_count++;
    finish_test();
  end
  initial begin
    {i_rst, i_wr, i_rd, i_wake_global_enable} = 4'h8;
    {i_main_power_on_reset, i_soft_reset, i_pci_reset} = 3'h0;
    {i_addr, i_wr_data} = 16'h0000;
    {i_wake_event, i_wake_source_enable} = 48'h000000000000;
    {m, req, rd} = 56'h0;
    void'($urandom(32'hBE87));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'h0;
    for (int k = 0; k < 600; k++) begin
      @(negedge i_clk);
      check("status", o_wake_status, m);
      check("request", o_wake_request, req);
      check("request_n", {23'h000000, o_wake_request_out_n}, {23'h000000, req == 0});
      check("rd_data", {16'h0000, o_rd_data}, {16'h0000, rd});
      // The model takes the inputs now on the wires, as the next edge will.
      req = m & i_wake_source_enable & {24{i_wake_global_enable}};
      rd = 8'h00;
      wmask = 24'h000000;
      if (i_addr >= 8'h05 && i_addr <= 8'h07) begin
        if (i_rd) rd = 8'(m >> (8 * (i_addr - 8'h05)));
        if (i_wr) wmask = {16'h0000, i_wr_data} << (8 * (i_addr - 8'h05));
      end
      if (i_main_power_on_reset || i_soft_reset || i_pci_reset) rd = 8'h00;
      m = (m & ~wmask) | i_wake_event;
      if (i_rst) {m, req, rd} = 56'h0;
      @(posedge i_clk);
      op = $urandom_range(2);
      i_wr <= op == 1;
      i_rd <= op == 2;
      i_addr <= 8'(8'h04 + $urandom_range(4));
      i_wr_data <= 8'($urandom);
      i_wake_event <= ($urandom_range(7) == 0) ? 24'($urandom) : 24'h000000;
      i_wake_source_enable <= 24'($urandom);
      i_wake_global_enable <= 1'($urandom);
      {i_main_power_on_reset, i_soft_reset, i_pci_reset} <=
        (op != 2 && $urandom_range(7) == 0) ? 3'($urandom) : 3'h0;
      i_rst <= (k == 300);
    end
    finish_test();
  end
endmodule : tb_top
